// *** bench/asdc_core_sva_sva.sv ***
// Purpose: port-level checks of the converter control
// Assumes: auxiliary select is tracked from config writes
// Notes: bound to every asdc_core instance
`timescale 1ns/100ps
`default_nettype none
module asdc_core_sva (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] scan_channel_mask_in,
    input wire logic dma_byte_count_select_in,
    input wire logic converter_interrupt_enable_in,
    input wire logic power_down_in,
    input wire logic dma_ack_in,
    input wire logic dma_req_out,
    input wire logic [7:0] dma_data_out,
    input wire logic [7:0] mux_external_out,
    input wire logic mux_reference_out,
    input wire logic mux_ground_out,
    input wire logic converting_out,
    input wire logic irq_req_out,
    input wire logic wake_out
);
    logic aux;
    logic [7:0] want;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            aux <= 1'b0;
            want <= 8'h01;
        end else begin
            want <= 8'h01 << sfr_wdata_in[2:0];
            if (sfr_wr_in && sfr_addr_in == asdc_pkg::ADDR_CONFIG_0) begin
                aux <= sfr_wdata_in[asdc_pkg::CFG_AUX];
            end
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    a_req_holds: assert property (dma_req_out && !dma_ack_in |=> dma_req_out)
        else $error("transfer request dropped before ack");
    a_byte_stable: assert property (dma_req_out && !dma_ack_in |=> $stable(dma_data_out))
        else $error("transfer byte changed before ack");
    a_one_byte: assert property (dma_req_out && dma_ack_in && dma_byte_count_select_in |=> !dma_req_out)
        else $error("one-byte transfer sent more");
    a_req_cause: assert property ($rose(dma_req_out) |-> $past(converting_out))
        else $error("transfer request without completion");
    a_done_gap: assert property ($fell(converting_out) |=> !converting_out)
        else $error("conversion restarted with done high");
    a_power_down: assert property (power_down_in && !converting_out |=> !converting_out)
        else $error("conversion started in power-down");
    a_mux_onehot: assert property ($onehot0({mux_external_out, mux_reference_out, mux_ground_out}))
        else $error("more than one input selected");
    a_chan_write: assert property (sfr_wr_in && sfr_addr_in == asdc_pkg::ADDR_CONTROL_0 && scan_channel_mask_in == 8'h00
        && !aux && !sfr_wdata_in[asdc_pkg::CTL_CHAN3] |=> mux_external_out == want)
        else $error("channel write not followed");
    a_wake_gate: assert property (wake_out == (irq_req_out && converter_interrupt_enable_in))
        else $error("wake does not follow interrupt");
endmodule : asdc_core_sva
bind asdc_core asdc_core_sva i_asdc_core_sva (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .scan_channel_mask_in(scan_channel_mask_in),
    .dma_byte_count_select_in(dma_byte_count_select_in), .power_down_in(power_down_in), .dma_ack_in(dma_ack_in),
    .converter_interrupt_enable_in(converter_interrupt_enable_in), .dma_req_out(dma_req_out),
    .dma_data_out(dma_data_out), .mux_external_out(mux_external_out), .mux_reference_out(mux_reference_out),
    .mux_ground_out(mux_ground_out), .converting_out(converting_out), .irq_req_out(irq_req_out),
    .wake_out(wake_out));
`default_nettype wire

// *** bench/asdc_dma_model.sv ***
// Purpose: transfer controller stand-in that takes result bytes
// Assumes: one ack pulse per byte after delay_in waiting cycles
// Notes: got keeps the bytes in the order taken
`timescale 1ns/100ps
`default_nettype none
module asdc_dma_model (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [3:0] delay_in,
    input wire logic dma_req_in,
    input wire logic [7:0] dma_data_in,
    output logic dma_ack_out
);
    logic [7:0] got[$];
    logic [3:0] wait_cnt;
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            dma_ack_out <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (dma_ack_out) begin
            got.push_back(dma_data_in);
            dma_ack_out <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (dma_req_in) begin
            // ack only while asked, so a dropped request ends the unit
            dma_ack_out <= wait_cnt >= delay_in;
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : asdc_dma_model
`default_nettype wire

// *** bench/testbench.sv ***
// Purpose: self-checking bench for the converter control
// Assumes: overflow inputs toggle every cycle, so halved sources tick every fourth cycle
// Notes: bytes are compared with layouts worked out from the justification and resolution rules
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [7:0] cfg = asdc_pkg::ADDR_CONFIG_0;
    localparam logic [7:0] ctl = asdc_pkg::ADDR_CONTROL_0;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, dma_byte_count_select = 1'b0, src = 1'b0, wmode = 1'b0, dmask = 1'b0;
    logic wie = 1'b0, cie = 1'b1, pd = 1'b0, ovf = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, mask = 8'h00, rdata, ddata, mext, v;
    logic [1:0] res = 2'h0;
    logic [11:0] wlo = 12'h000, whi = 12'hFFF, code = 12'hFFF;
    logic [3:0] delay = 4'h0;
    logic [15:0] e;
    logic ack, req, conv, irq, wake, mref, mgnd;
    int num_errors = 0, comparisons = 0, cycles = 0, n, d;
    asdc_core i_asdc_core (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .sfr_addr_in(addr), .sfr_wr_in(sfr_wr),
        .sfr_rd_in(sfr_rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .scan_channel_mask_in(mask),
        .result_resolution_field_in(res), .dma_byte_count_select_in(dma_byte_count_select), .dma_request_source_in(src),
        .window_mode_bit_in(wmode), .window_low_in(wlo), .window_high_in(whi), .done_interrupt_mask_in(dmask),
        .window_interrupt_enable_in(wie), .converter_interrupt_enable_in(cie), .power_down_in(pd),
        .timer_zero_overflow_in(ovf), .uart_baud_generator_overflow_in(ovf), .timer_two_overflow_in(ovf),
        .sample_code_in(code), .dma_ack_in(ack), .dma_req_out(req), .dma_data_out(ddata),
        .mux_external_out(mext), .mux_reference_out(mref), .mux_ground_out(mgnd), .converting_out(conv),
        .irq_req_out(irq), .wake_out(wake));
    asdc_dma_model i_asdc_dma_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .delay_in(delay),
        .dma_req_in(req), .dma_data_in(ddata), .dma_ack_out(ack));
    always #10 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) #1 ovf <= ~ovf;
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] dt);
        addr = a;
        wdata = dt;
        sfr_wr = w;
        sfr_rd = !w;
        @(posedge clk_sys_in);
        #1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask : acc
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] dt);
        acc(a, 1'b1, dt);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        acc(a, 1'b0, 8'h00);
        chk(rdata, exp);
    endtask : rd_reg
    task automatic finish(output int cnt);
        int k;
        cnt = 0;
        k = 0;
        while ((conv || req) && k < 2000) begin
            @(posedge clk_sys_in);
            #1;
            cnt += int'(conv);
            k++;
        end
        chk({7'h00, conv | req}, 8'h00);
    endtask : finish
    task automatic run;
        i_asdc_dma_model.got.delete();
        wr_reg(ctl, 8'h80);
        wr_reg(ctl, 8'h88);
        finish(n);
    endtask : run
    function automatic logic [15:0] layout(input logic [11:0] c, input logic [1:0] r, input logic rj);
        logic [11:0] t;
        t = r == 2'h0 ? c : (r == 2'h1 ? {c[11:2], 2'h0} : {c[11:4], 4'h0});
        return rj ? 16'(t >> (r[1] ? 4 : 2 * r[0])) : {t, 4'h0};
    endfunction : layout
    task automatic give_verdict;
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (12) @(posedge clk_sys_in);
        #1;
        rst_in = 1'b0;
        rd_reg(cfg, asdc_pkg::RESET_CONFIG_0);
        rd_reg(ctl, asdc_pkg::RESET_CONTROL_0);
        rd_reg(8'h10, 8'h00);
        chk(mext, 8'h01);
        wr_reg(ctl, 8'h80);
        repeat (250) @(posedge clk_sys_in); // settle time after enable
        #1;
        for (int i = 0; i < 24; i++) begin
            code = i[4] ? 12'hB6D : 12'hFFF;
            res = 2'(i % 3);
            dma_byte_count_select = i[0];
            delay = 4'(3 * (i % 3));
            wr_reg(cfg, {3'h0, i[3], 4'h0});
            run();
            e = layout(code, res, i[3]);
            chk(8'(i_asdc_dma_model.got.size()), dma_byte_count_select ? 8'h01 : 8'h02);
            chk(i_asdc_dma_model.got[0], dma_byte_count_select && !i[3] ? e[15:8] : e[7:0]);
            if (!dma_byte_count_select) chk(i_asdc_dma_model.got[1], e[15:8]);
            rd_reg(asdc_pkg::ADDR_RESULT_LOW, e[7:0]);
            rd_reg(asdc_pkg::ADDR_RESULT_HIGH, e[15:8]);
            rd_reg(ctl, 8'hD0);
        end
        chk({6'h00, irq, wake}, 8'h03);
        cie = 1'b0;
        dmask = 1'b1;
        #1;
        chk({6'h00, irq, wake}, 8'h00);
        wie = 1'b1;
        #1;
        chk({7'h00, irq}, 8'h01);
        wr_reg(ctl, 8'hD8);
        chk({7'h00, conv}, 8'h00);
        rd_reg(ctl, 8'hD0);
        wr_reg(ctl, 8'h80);
        wr_reg(ctl, 8'h88);
        wr_reg(ctl, 8'h80);
        chk({7'h00, conv}, 8'h01);
        finish(n);
        rd_reg(ctl, 8'hD0);
        res = 2'h0;
        dma_byte_count_select = 1'b0;
        wmode = 1'b1;
        wlo = 12'h100;
        whi = 12'h200;
        src = 1'b1;
        code = 12'h050;
        run();
        chk(8'(i_asdc_dma_model.got.size()), 8'h02);
        rd_reg(ctl, 8'hD0);
        code = 12'h150;
        run();
        chk(8'(i_asdc_dma_model.got.size()), 8'h00);
        rd_reg(ctl, 8'h90);
        for (int tm = 0; tm < 4; tm++) begin
            wr_reg(cfg, 8'(tm));
            wr_reg(ctl, 8'h80);
            repeat (3) @(posedge clk_sys_in);
            #1;
            chk({7'h00, conv}, {7'h00, tm != 0});
            finish(n);
            wr_reg(cfg, 8'h00);
        end
        for (int k = 0; k < 8; k++) begin
            d = k < 6 ? 1 << k : 4;
            wr_reg(cfg, {3'(k), 5'h00});
            run();
            chk({7'h00, n + 1 + d + 2 >= 30 * d && n + 1 <= 30 * d + d + 2}, 8'h01);
        end
        wr_reg(cfg, 8'h00);
        pd = 1'b1;
        wr_reg(ctl, 8'h80);
        wr_reg(ctl, 8'h88);
        repeat (40) @(posedge clk_sys_in);
        #1;
        chk({7'h00, conv}, 8'h00);
        wr_reg(ctl, 8'h00); // converter off before the low-power state ends
        pd = 1'b0;
        wr_reg(cfg, 8'h08);
        wr_reg(ctl, 8'h80);
        chk({6'h00, mref, mgnd}, 8'h02);
        wr_reg(ctl, 8'h81);
        chk({6'h00, mref, mgnd}, 8'h01);
        wr_reg(cfg, 8'h00);
        wr_reg(ctl, 8'h85);
        chk(mext, 8'h20);
        repeat (250) @(posedge clk_sys_in); // settle time after re-enable
        #1;
        mask = 8'h84; // setup order kept: clock, layout, enable, mask, trigger
        for (int s = 0; s < 3; s++) begin
            acc(ctl, 1'b0, 8'h00);
            v = rdata & 8'hAF; // read-modify-write keeps the channel
            wr_reg(ctl, v);
            wr_reg(ctl, v | 8'h08);
            finish(n);
            chk(mext, s[0] ? 8'h04 : 8'h80);
        end
        mask = 8'h00;
        wr_reg(ctl, 8'h83);
        chk(mext, 8'h08);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire

// *** rtl/asdc_core.sv ***
// Purpose: conversion sequencing, scan, result layout and byte transfer
// Assumes: analog sampling is outside; its code arrives on sample_code_in
// Notes: control inputs without a register come from other configuration logic
`timescale 1ns/100ps
`default_nettype none
module asdc_core (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic [7:0] scan_channel_mask_in,
    input wire logic [1:0] result_resolution_field_in,
    input wire logic dma_byte_count_select_in,
    input wire logic dma_request_source_in,
    input wire logic window_mode_bit_in,
    input wire logic [11:0] window_low_in,
    input wire logic [11:0] window_high_in,
    input wire logic done_interrupt_mask_in,
    input wire logic window_interrupt_enable_in,
    input wire logic converter_interrupt_enable_in,
    input wire logic power_down_in,
    input wire logic timer_zero_overflow_in,
    input wire logic uart_baud_generator_overflow_in,
    input wire logic timer_two_overflow_in,
    input wire logic [11:0] sample_code_in,
    input wire logic dma_ack_in,
    output logic dma_req_out,
    output logic [7:0] dma_data_out,
    output logic [7:0] mux_external_out,
    output logic mux_reference_out,
    output logic mux_ground_out,
    output logic converting_out,
    output logic irq_req_out,
    output logic wake_out
);
    typedef enum logic {ASDC_IDLE, ASDC_CONVERT} asdc_state_t;

    function automatic logic [2:0] asdc_next_chan(input logic [7:0] m, input logic [2:0] c);
        logic [2:0] idx;
        logic found;
        asdc_next_chan = c;
        found = 1'b0;
        // walking upward from the current channel gives the wrap for free
        for (int i = 1; i <= 8; i++) begin
            idx = c + 3'(i);
            if (m[idx] && !found) begin
                asdc_next_chan = idx;
                found = 1'b1;
            end
        end
    endfunction : asdc_next_chan

    asdc_state_t state, next_state;
    logic [7:0] config_0, next_config_0;
    logic enable, next_enable;
    logic window_flag, next_window_flag;
    logic done_flag, next_done_flag;
    logic start_bit, next_start_bit;
    logic [3:0] chan, next_chan;
    logic [7:0] res_hi, next_res_hi;
    logic [7:0] res_lo, next_res_lo;
    logic [4:0] div_cnt, next_div_cnt;
    logic [4:0] conv_cnt, next_conv_cnt;
    logic half_tog, next_half_tog;
    logic dma_req, next_dma_req;
    logic dma_second, next_dma_second;
    logic [7:0] dma_data, next_dma_data;
    logic [7:0] rdata, next_rdata;
    logic [7:0] mux_ext, next_mux_ext;
    logic mux_ref, next_mux_ref;
    logic mux_gnd, next_mux_gnd;
    logic wr_ctl, wr_cfg, tick, trig, finish, win_set, done_set;
    logic [2:0] cks;
    logic [1:0] tm;
    logic [4:0] div_mask;
    logic [11:0] code, shifted;
    logic in_window;

    always_comb begin
        wr_ctl = sfr_wr_in && (sfr_addr_in == asdc_pkg::ADDR_CONTROL_0);
        wr_cfg = sfr_wr_in && (sfr_addr_in == asdc_pkg::ADDR_CONFIG_0);
        cks = config_0[asdc_pkg::CFG_CLK_HI:asdc_pkg::CFG_CLK_LO];
        tm = config_0[asdc_pkg::CFG_TM_HI:asdc_pkg::CFG_TM_LO];
        // conversion clock: divided system clock or halved overflow
        div_mask = 5'((6'h01 << cks) - 6'h01);
        next_div_cnt = div_cnt + 5'h01;
        next_half_tog = half_tog;
        tick = 1'b0;
        if (cks == asdc_pkg::CKS_BAUD || cks == asdc_pkg::CKS_TIMER2) begin
            if ((cks == asdc_pkg::CKS_BAUD) ? uart_baud_generator_overflow_in : timer_two_overflow_in) begin
                next_half_tog = ~half_tog;
                tick = half_tog;
            end
        end else begin
            tick = ((div_cnt & div_mask) == div_mask);
        end
        // start source by trigger mode
        case (tm)
            asdc_pkg::TM_SOFTWARE: trig = start_bit;
            asdc_pkg::TM_TIMER0: trig = timer_zero_overflow_in;
            asdc_pkg::TM_FREE: trig = 1'b1;
            asdc_pkg::TM_BAUD: trig = uart_baud_generator_overflow_in;
            default: trig = 1'b0;
        endcase
        // resolution reduction clears dropped bits
        case (result_resolution_field_in)
            asdc_pkg::RES_12: begin
                code = sample_code_in;
                shifted = sample_code_in;
            end
            asdc_pkg::RES_10: begin
                code = {sample_code_in[11:2], 2'h0};
                shifted = {2'h0, sample_code_in[11:2]};
            end
            default: begin
                code = {sample_code_in[11:4], 4'h0};
                shifted = {4'h0, sample_code_in[11:4]};
            end
        endcase
        // inside when low <= code <= high; mode one inverts
        in_window = (code >= window_low_in) && (code <= window_high_in);
        next_state = state;
        next_config_0 = config_0;
        next_enable = enable;
        next_window_flag = window_flag;
        next_done_flag = done_flag;
        next_start_bit = start_bit;
        next_chan = chan;
        next_res_hi = res_hi;
        next_res_lo = res_lo;
        next_conv_cnt = conv_cnt;
        finish = 1'b0;
        if (wr_cfg) begin
            next_config_0 = sfr_wdata_in;
        end
        if (wr_ctl) begin
            next_enable = sfr_wdata_in[asdc_pkg::CTL_ENABLE];
            next_chan = {sfr_wdata_in[asdc_pkg::CTL_CHAN3], sfr_wdata_in[2:0]};
            // flags only clear from software; a one leaves them alone
            if (!sfr_wdata_in[asdc_pkg::CTL_WINDOW]) begin
                next_window_flag = 1'b0;
            end
            if (!sfr_wdata_in[asdc_pkg::CTL_DONE]) begin
                next_done_flag = 1'b0;
            end
            // a zero write to start has no effect; blocked while done high
            if (sfr_wdata_in[asdc_pkg::CTL_START] && !done_flag) begin
                next_start_bit = 1'b1;
            end
        end
        case (state)
            ASDC_IDLE: begin
                next_conv_cnt = 5'h00;
                // power-down stalls starts; idle mode is not seen here
                if (enable && !power_down_in && !done_flag && trig &&
                    (tm == asdc_pkg::TM_SOFTWARE || !start_bit)) begin
                    next_state = ASDC_CONVERT;
                    next_start_bit = 1'b1;
                end
            end
            ASDC_CONVERT: begin
                if (!enable) begin
                    next_state = ASDC_IDLE;
                    next_start_bit = 1'b0;
                end else if (tick && !power_down_in) begin
                    next_conv_cnt = conv_cnt + 5'h01;
                    if (conv_cnt == asdc_pkg::CONV_CLOCKS - 5'h01) begin
                        finish = 1'b1;
                        next_state = ASDC_IDLE;
                    end
                end
            end
            default: next_state = ASDC_IDLE;
        endcase
        win_set = finish && (in_window != window_mode_bit_in);
        done_set = finish;
        if (finish) begin
            next_start_bit = 1'b0;
            if (config_0[asdc_pkg::CFG_RJ]) begin
                next_res_hi = {4'h0, shifted[11:8]};
                next_res_lo = shifted[7:0];
            end else begin
                next_res_hi = code[11:4];
                next_res_lo = {code[3:0], 4'h0};
            end
            // channel scanning; clear mask keeps software control
            if (scan_channel_mask_in != 8'h00) begin
                next_chan = {1'b0, asdc_next_chan(scan_channel_mask_in, chan[2:0])};
            end
        end
        // hardware set wins over a same-cycle software clear
        if (win_set) begin
            next_window_flag = 1'b1;
        end
        if (done_set) begin
            next_done_flag = 1'b1;
        end
        if (!enable) begin
            next_start_bit = next_start_bit && wr_ctl && sfr_wdata_in[asdc_pkg::CTL_ENABLE];
        end
        // channel decode for the analog multiplexer
        next_mux_ext = 8'h00;
        next_mux_ref = 1'b0;
        next_mux_gnd = 1'b0;
        if (!next_config_0[asdc_pkg::CFG_AUX]) begin
            if (!next_chan[3]) begin
                next_mux_ext[next_chan[2:0]] = 1'b1;
            end
        end else begin
            next_mux_ref = (next_chan == 4'h0);
            next_mux_gnd = (next_chan == 4'h1);
        end
    end

    // result transfer: request on chosen event, bytes handed out on ack
    always_comb begin
        next_dma_req = dma_req;
        next_dma_second = dma_second;
        next_dma_data = dma_data;
        if (dma_req && dma_ack_in) begin
            if (!dma_byte_count_select_in && !dma_second) begin
                next_dma_second = 1'b1;
                next_dma_data = res_hi;
            end else begin
                next_dma_req = 1'b0;
                next_dma_second = 1'b0;
            end
        end
        // a new event restarts the byte sequence with fresh data
        if (dma_request_source_in ? win_set : done_set) begin
            next_dma_req = 1'b1;
            next_dma_second = 1'b0;
            if (!dma_byte_count_select_in) begin
                next_dma_data = next_res_lo;
            end else begin
                // significant byte follows justification
                next_dma_data = config_0[asdc_pkg::CFG_RJ] ? next_res_lo : next_res_hi;
            end
        end
    end

    always_comb begin
        next_rdata = rdata;
        if (sfr_rd_in) begin
            case (sfr_addr_in)
                asdc_pkg::ADDR_CONFIG_0: next_rdata = config_0;
                asdc_pkg::ADDR_CONTROL_0: next_rdata = {enable, window_flag, chan[3], done_flag,
                                                        start_bit, chan[2:0]};
                asdc_pkg::ADDR_RESULT_LOW: next_rdata = res_lo;
                asdc_pkg::ADDR_RESULT_HIGH: next_rdata = res_hi;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ASDC_IDLE;
            config_0 <= asdc_pkg::RESET_CONFIG_0;
            enable <= asdc_pkg::RESET_CONTROL_0[asdc_pkg::CTL_ENABLE];
            window_flag <= asdc_pkg::RESET_CONTROL_0[asdc_pkg::CTL_WINDOW];
            done_flag <= asdc_pkg::RESET_CONTROL_0[asdc_pkg::CTL_DONE];
            start_bit <= asdc_pkg::RESET_CONTROL_0[asdc_pkg::CTL_START];
            chan <= 4'h0;
            res_hi <= 8'h00;
            res_lo <= 8'h00;
            div_cnt <= 5'h00;
            conv_cnt <= 5'h00;
            half_tog <= 1'b0;
            dma_req <= 1'b0;
            dma_second <= 1'b0;
            dma_data <= 8'h00;
            rdata <= 8'h00;
            mux_ext <= 8'h01;
            mux_ref <= 1'b0;
            mux_gnd <= 1'b0;
        end else begin
            state <= next_state;
            config_0 <= next_config_0;
            enable <= next_enable;
            window_flag <= next_window_flag;
            done_flag <= next_done_flag;
            start_bit <= next_start_bit;
            chan <= next_chan;
            res_hi <= next_res_hi;
            res_lo <= next_res_lo;
            div_cnt <= next_div_cnt;
            conv_cnt <= next_conv_cnt;
            half_tog <= next_half_tog;
            dma_req <= next_dma_req;
            dma_second <= next_dma_second;
            dma_data <= next_dma_data;
            rdata <= next_rdata;
            mux_ext <= next_mux_ext;
            mux_ref <= next_mux_ref;
            mux_gnd <= next_mux_gnd;
        end
    end

    assign sfr_rdata_out = rdata;
    assign dma_req_out = dma_req;
    assign dma_data_out = dma_data;
    assign mux_external_out = mux_ext;
    assign mux_reference_out = mux_ref;
    assign mux_ground_out = mux_gnd;
    assign converting_out = (state == ASDC_CONVERT);
    // done source masked by ignore bit, window source by its enable
    assign irq_req_out = (done_flag && !done_interrupt_mask_in) || (window_flag && window_interrupt_enable_in);
    assign wake_out = irq_req_out && converter_interrupt_enable_in;
endmodule : asdc_core
`default_nettype wire

// *** rtl/asdc_pkg.sv ***
// Purpose: constants of the converter scan, result and transfer control
// Assumes: 50 MHz system clock, 8-bit special function register port
// Notes: offsets are the register addresses on the special function port
package asdc_pkg;
    localparam logic [7:0] ADDR_CONFIG_0 = 8'hC3;
    localparam logic [7:0] ADDR_CONTROL_0 = 8'hC4;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'hC5;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hC6;
    localparam logic [7:0] RESET_CONFIG_0 = 8'h00;
    localparam logic [7:0] RESET_CONTROL_0 = 8'h00;
    localparam int CTL_ENABLE = 7;
    localparam int CTL_WINDOW = 6;
    localparam int CTL_CHAN3 = 5;
    localparam int CTL_DONE = 4;
    localparam int CTL_START = 3;
    localparam int CFG_CLK_HI = 7;
    localparam int CFG_CLK_LO = 5;
    localparam int CFG_RJ = 4;
    localparam int CFG_AUX = 3;
    localparam int CFG_SAMPLE_HOLD_FLAG = 2;
    localparam int CFG_TM_HI = 1;
    localparam int CFG_TM_LO = 0;
    localparam logic [4:0] CONV_CLOCKS = 5'h1E;
    localparam logic [1:0] TM_SOFTWARE = 2'h0;
    localparam logic [1:0] TM_TIMER0 = 2'h1;
    localparam logic [1:0] TM_FREE = 2'h2;
    localparam logic [1:0] TM_BAUD = 2'h3;
    localparam logic [2:0] CKS_BAUD = 3'h6;
    localparam logic [2:0] CKS_TIMER2 = 3'h7;
    localparam logic [1:0] RES_12 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
endpackage : asdc_pkg
